// ===== logic/asm_pkg.sv
// Purpose: shared constants for the analog speed mixing block
// Assumes: 32-bit axi4-lite register map, byte addresses
// Notes: scaled values are signed, full scale is +/-3200
package asm_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
    localparam logic [7:0] OFF_RAW = 8'h0c;
    localparam logic [7:0] OFF_SCALED = 8'h10;
    localparam logic [7:0] OFF_TARGET = 8'h14;
    localparam logic [7:0] OFF_CAL_BASE = 8'h20;
    localparam logic [7:0] CAL_SEL_MASK = 8'he0;
    localparam logic [3:0] CAL_RANGE = 4'h0;
    localparam logic [3:0] CAL_NEUTRAL = 4'h4;
    localparam logic [3:0] CAL_SLOPE = 4'h8;
    localparam logic [3:0] CAL_OPT = 4'hc;
    // control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MIX_LSB = 2;
    localparam int CTRL_IGN_DISC_BIT = 4;
    localparam int CTRL_ALT_LSB = 8;
    localparam logic [31:0] CTRL_MASK = 32'h0000_0f1f;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // input modes, mixing modes, alternate uses
    localparam logic [1:0] MODE_SERIAL = 2'h0;
    localparam logic [1:0] MODE_ANALOG = 2'h1;
    localparam logic [1:0] MODE_RC = 2'h2;
    localparam logic [1:0] MIX_NONE = 2'h0;
    localparam logic [1:0] MIX_LEFT = 2'h1;
    localparam logic [1:0] MIX_RIGHT = 2'h2;
    localparam logic [1:0] ALT_NONE = 2'h0;
    localparam logic [1:0] ALT_FWD_LIMIT = 2'h1;
    localparam logic [1:0] ALT_REV_LIMIT = 2'h2;
    localparam logic [1:0] ALT_KILL = 2'h3;
    // status bits
    localparam int ST_W = 4;
    localparam int ST_SAMPLE = 0;
    localparam int ST_LIMIT_KILL = 1;
    localparam int ST_REQ_INVALID = 2;
    localparam int ST_DISCONNECT = 3;
    // conversion and scaling
    localparam int RAW_W = 12;
    localparam int ADC_STEP_UV = 800;
    localparam logic [11:0] RAW_FULL = 12'hfff;
    localparam logic [15:0] SCALE_FULL = 16'h0c80;
    localparam logic [15:0] SWITCH_THRESH = 16'h0640;
    localparam int SLOPE_SHIFT = 8;
    // calibration reset values
    localparam logic [31:0] RANGE_RST = 32'h0fff_0000;
    localparam logic [31:0] NEUTRAL_RST = 32'h0800_07ff;
    localparam logic [31:0] SLOPE_RST = 32'h0190_0190;
    localparam logic [31:0] FIELD12_MASK = 32'h0fff_0fff;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : asm_pkg

// ===== logic/asm_analog_mixer.sv
// Purpose: analog channel scaling, mixing and limit/kill switch logic
// Assumes: one strobe carries both 12-bit channels; inputs synchronous
// Notes: registers over axi4-lite; speed target is held until the next sample
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - sample both channels, keep latest values
// - measure and report in every input mode
// - unsigned 12-bit result, 0.8 mV step
// - analog mode derives speed via calibration, mixing
// - calibration maps extremes to full speeds
// - no mixing uses first channel only
// - mixing: throttle first, steering second channel
// - left mixing sums throttle and steering
// - right mixing subtracts steering from throttle
// - unused channel may be limit or kill
// - switch active above half forward value
// - disconnected switch gives error or active
// - disconnect detection can be switched off
// - raw value spans 0 to 4095
// - switch threshold is scaled value 1600
// - limits block their direction, raise error
// - switch channels required; invalid stops motor
module asm_analog_mixer #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic adc_sample_valid,
    input wire logic [11:0] throttle_channel_value,
    input wire logic [11:0] steering_channel_value,
    input wire logic [1:0] pot_disconnect,
    output logic [15:0] target_speed,
    output logic target_speed_valid,
    output logic limit_kill_error,
    output logic required_invalid_error,
    output logic irq
);
    // register storage; range, neutral and slope words hold a low and a high half
    logic [31:0] ctrl_reg;
    logic [asm_pkg::ST_W-1:0] status_reg, status_next, mask_reg, w1c_comb;
    logic [31:0] range_reg [2], neutral_reg [2], slope_reg [2];
    logic invert_reg [2];
    // sample pipeline
    logic [11:0] raw_reg [2];
    logic [1:0] disc_reg, chan_ok_reg, chan_disc_reg, chan_ok_comb, chan_disc_comb;
    logic stage1_reg, stage2_reg;
    logic [15:0] scaled_reg [2], scaled_comb [2], speed_comb;
    // speed stage; switch state is {kill, rev limit, fwd limit}
    logic lk_err_comb, req_err_comb;
    logic [2:0] switch_state_reg, switch_state_comb;
    // bus side
    logic aw_held, w_held, wr_fire, rd_hit_comb, wr_hit_comb;
    logic [ADDR_W-1:0] awaddr_held;
    logic [31:0] wdata_held, rdata_comb;
    logic [3:0] wstrb_held;
    // control fields
    wire logic [1:0] mode = ctrl_reg[asm_pkg::CTRL_MODE_LSB +: 2];
    wire logic [1:0] mix = ctrl_reg[asm_pkg::CTRL_MIX_LSB +: 2];
    wire logic ign_disc = ctrl_reg[asm_pkg::CTRL_IGN_DISC_BIT];
    wire logic analog_mode = (mode == asm_pkg::MODE_ANALOG);
    wire logic mixing = (mix == asm_pkg::MIX_LEFT) || (mix == asm_pkg::MIX_RIGHT);
    // byte-lane merge for a register write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge
    // capture both channels in every mode so they stay readable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            raw_reg[0] <= 12'h000;
            raw_reg[1] <= 12'h000;
            {disc_reg, stage1_reg} <= 3'h0;
        end else begin
            stage1_reg <= adc_sample_valid;
            if (adc_sample_valid) begin
                raw_reg[0] <= throttle_channel_value;
                raw_reg[1] <= steering_channel_value;
                disc_reg <= pot_disconnect;
            end
        end
    end
    // per-channel scaling: error window, neutral band, piecewise slope, clamp
    for (genvar g = 0; g < 2; g++) begin : g_chan
        wire logic [11:0] err_min = range_reg[g][11:0];
        wire logic [11:0] err_max = range_reg[g][27:16];
        wire logic [11:0] neu_lo = neutral_reg[g][11:0];
        wire logic [11:0] neu_hi = neutral_reg[g][27:16];
        logic [27:0] prod;
        logic [19:0] mag;
        logic [15:0] mag_c;
        logic neg;
        always_comb begin
            {neg, prod} = 29'h0;
            if (raw_reg[g] > neu_hi) begin
                // above neutral: toward full forward
                prod = {16'h0, 12'(raw_reg[g] - neu_hi)} * {12'h0, slope_reg[g][15:0]};
            end else if (raw_reg[g] < neu_lo) begin
                // below neutral: toward full reverse
                prod = {16'h0, 12'(neu_lo - raw_reg[g])} * {12'h0, slope_reg[g][31:16]};
                neg = 1'b1;
            end
            mag = prod[27:asm_pkg::SLOPE_SHIFT];
            // saturate so a steep slope cannot overshoot full speed
            mag_c = (mag > 20'(asm_pkg::SCALE_FULL)) ? asm_pkg::SCALE_FULL : mag[15:0];
            scaled_comb[g] = ((neg ^ invert_reg[g]) ? 16'(-mag_c) : mag_c);
            // out of the error window or detected open: channel invalid
            chan_disc_comb[g] = disc_reg[g] & ~ign_disc;
            chan_ok_comb[g] = (raw_reg[g] >= err_min) && (raw_reg[g] <= err_max)
                && !chan_disc_comb[g];
        end
    end
    // scaled stage register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scaled_reg[0] <= 16'h0000;
            scaled_reg[1] <= 16'h0000;
            {chan_ok_reg, chan_disc_reg, stage2_reg} <= 5'h00;
        end else begin
            stage2_reg <= stage1_reg;
            if (stage1_reg) begin
                scaled_reg[0] <= scaled_comb[0];
                scaled_reg[1] <= scaled_comb[1];
                chan_ok_reg <= chan_ok_comb;
                chan_disc_reg <= chan_disc_comb;
            end
        end
    end
    // mixing, switches and required-channel checks
    always_comb begin
        logic signed [16:0] sum, full, t0, t1;
        logic signed [15:0] spd;
        logic [1:0] speed_use, is_sw, active;
        logic fwd, rev, kill;
        sum = 17'sh0;
        spd = 16'sh0;
        {speed_use, is_sw, active} = 6'h00;
        {fwd, rev, kill} = 3'b000;
        t0 = 17'(signed'(scaled_reg[0]));
        t1 = 17'(signed'(scaled_reg[1]));
        full = 17'(signed'({1'b0, asm_pkg::SCALE_FULL}));
        unique case (mix)
            asm_pkg::MIX_LEFT: sum = t0 + t1;
            asm_pkg::MIX_RIGHT: sum = t0 - t1;
            default: sum = t0;
        endcase
        // clamp the mix to the full forward and reverse limits
        if (sum > full) begin
            spd = 16'(full);
        end else if (sum < -full) begin
            spd = 16'(-full);
        end else begin
            spd = sum[15:0];
        end
        // channel 0 throttles; channel 1 steers only while mixing
        speed_use = analog_mode ? {mixing, 1'b1} : 2'b00;
        for (int c = 0; c < 2; c++) begin
            is_sw[c] = !speed_use[c] && (ctrl_reg[asm_pkg::CTRL_ALT_LSB + 2*c +: 2]
                != asm_pkg::ALT_NONE);
            active[c] = is_sw[c] && chan_ok_reg[c]
                && (signed'(scaled_reg[c]) > signed'(asm_pkg::SWITCH_THRESH));
            unique case (ctrl_reg[asm_pkg::CTRL_ALT_LSB + 2*c +: 2])
                asm_pkg::ALT_FWD_LIMIT: fwd = fwd | active[c];
                asm_pkg::ALT_REV_LIMIT: rev = rev | active[c];
                asm_pkg::ALT_KILL: kill = kill | active[c];
                default: ;
            endcase
        end
        if (!analog_mode) begin
            spd = 16'sh0; // speed comes from elsewhere in other modes
        end
        switch_state_comb = {kill, rev, fwd};
        lk_err_comb = kill || (fwd && spd > 16'sh0) || (rev && spd < 16'sh0);
        // any switch channel or speed channel that is invalid stops the motor
        req_err_comb = |((is_sw | speed_use) & ~chan_ok_reg);
        speed_comb = (lk_err_comb || req_err_comb) ? 16'h0000 : 16'(spd);
    end
    // speed target and error outputs, refreshed once per sample
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            target_speed <= 16'h0000;
            {target_speed_valid, limit_kill_error, required_invalid_error} <= 3'h0;
            switch_state_reg <= 3'h0;
        end else if (stage2_reg) begin
            target_speed <= speed_comb;
            target_speed_valid <= analog_mode && !lk_err_comb && !req_err_comb;
            limit_kill_error <= lk_err_comb;
            required_invalid_error <= req_err_comb;
            switch_state_reg <= switch_state_comb;
        end
    end
    // write channel: address and data taken in either order, answer after both
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awaddr_held <= '0;
            wdata_held <= 32'h0;
            wstrb_held <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= asm_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                awaddr_held <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                wdata_held <= s_axi_wdata;
                wstrb_held <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit_comb ? asm_pkg::RESP_OKAY : asm_pkg::RESP_SLVERR;
            end
            // readies reopen only after the response is taken: one write at a time
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end
    // write decode: writable addresses and status bits to clear
    always_comb begin
        logic [7:0] a;
        a = 8'(awaddr_held);
        wr_hit_comb = (a == asm_pkg::OFF_CTRL) || (a == asm_pkg::OFF_STATUS)
            || (a == asm_pkg::OFF_IRQ_MASK)
            || ((a & asm_pkg::CAL_SEL_MASK) == asm_pkg::OFF_CAL_BASE);
        w1c_comb = '0;
        if (wr_fire && a == asm_pkg::OFF_STATUS && wstrb_held[0]) begin
            w1c_comb = wdata_held[asm_pkg::ST_W-1:0];
        end
    end
    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= asm_pkg::CTRL_RST;
            mask_reg <= '0;
            for (int c = 0; c < 2; c++) begin
                range_reg[c] <= asm_pkg::RANGE_RST;
                neutral_reg[c] <= asm_pkg::NEUTRAL_RST;
                slope_reg[c] <= asm_pkg::SLOPE_RST;
                invert_reg[c] <= 1'b0;
            end
        end else if (wr_fire) begin
            if (8'(awaddr_held) == asm_pkg::OFF_CTRL) begin
                ctrl_reg <= merge(ctrl_reg, wdata_held, wstrb_held) & asm_pkg::CTRL_MASK;
            end else if (8'(awaddr_held) == asm_pkg::OFF_IRQ_MASK && wstrb_held[0]) begin
                mask_reg <= wdata_held[asm_pkg::ST_W-1:0];
            end else if ((8'(awaddr_held) & asm_pkg::CAL_SEL_MASK) == asm_pkg::OFF_CAL_BASE) begin
                // channel is picked by address bit 4, the word by bits 3:0
                unique case (awaddr_held[3:0])
                    asm_pkg::CAL_RANGE: range_reg[awaddr_held[4]] <= merge(
                        range_reg[awaddr_held[4]], wdata_held, wstrb_held) & asm_pkg::FIELD12_MASK;
                    asm_pkg::CAL_NEUTRAL: neutral_reg[awaddr_held[4]] <= merge(
                        neutral_reg[awaddr_held[4]], wdata_held, wstrb_held)
                        & asm_pkg::FIELD12_MASK;
                    asm_pkg::CAL_SLOPE: slope_reg[awaddr_held[4]] <= merge(
                        slope_reg[awaddr_held[4]], wdata_held, wstrb_held);
                    asm_pkg::CAL_OPT: if (wstrb_held[0]) begin
                        invert_reg[awaddr_held[4]] <= wdata_held[0];
                    end
                    default: ;
                endcase
            end
        end
    end
    // sticky status: a new event in the clearing cycle survives the clear
    always_comb begin
        status_next = status_reg & ~w1c_comb;
        status_next[asm_pkg::ST_SAMPLE] |= stage2_reg;
        status_next[asm_pkg::ST_LIMIT_KILL] |= stage2_reg & lk_err_comb;
        status_next[asm_pkg::ST_REQ_INVALID] |= stage2_reg & req_err_comb;
        status_next[asm_pkg::ST_DISCONNECT] |= stage2_reg & |chan_disc_reg;
    end
    // status and interrupt level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= '0;
            irq <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq <= |(status_next & mask_reg);
        end
    end
    // read decode
    always_comb begin
        logic [7:0] a;
        a = 8'(s_axi_araddr);
        rd_hit_comb = 1'b1;
        rdata_comb = 32'h0;
        if (a == asm_pkg::OFF_CTRL) begin
            rdata_comb = ctrl_reg;
        end else if (a == asm_pkg::OFF_STATUS) begin
            rdata_comb = 32'(status_reg);
        end else if (a == asm_pkg::OFF_IRQ_MASK) begin
            rdata_comb = 32'(mask_reg);
        end else if (a == asm_pkg::OFF_RAW) begin
            rdata_comb = {4'h0, raw_reg[1], 4'h0, raw_reg[0]};
        end else if (a == asm_pkg::OFF_SCALED) begin
            rdata_comb = {scaled_reg[1], scaled_reg[0]};
        end else if (a == asm_pkg::OFF_TARGET) begin
            rdata_comb = {8'h0, chan_ok_reg, switch_state_reg, required_invalid_error,
                limit_kill_error, target_speed_valid, target_speed};
        end else if ((a & asm_pkg::CAL_SEL_MASK) == asm_pkg::OFF_CAL_BASE) begin
            unique case (a[3:0])
                asm_pkg::CAL_RANGE: rdata_comb = range_reg[a[4]];
                asm_pkg::CAL_NEUTRAL: rdata_comb = neutral_reg[a[4]];
                asm_pkg::CAL_SLOPE: rdata_comb = slope_reg[a[4]];
                asm_pkg::CAL_OPT: rdata_comb = {31'h0, invert_reg[a[4]]};
                default: rd_hit_comb = 1'b0;
            endcase
        end else begin
            rd_hit_comb = 1'b0;
        end
    end
    // read channel: one read in flight, answer one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= asm_pkg::RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_arready <= 1'b0;
            s_axi_rdata <= rdata_comb;
            s_axi_rresp <= rd_hit_comb ? asm_pkg::RESP_OKAY : asm_pkg::RESP_SLVERR;
        end
    end
endmodule : asm_analog_mixer
`default_nettype wire

// ===== test/asm_props.sv
// Purpose: port-level checks on the analog speed mixer
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to every mixer instance below
`timescale 1ns/10ps
`default_nettype none
module asm_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic adc_sample_valid,
    input wire logic [15:0] target_speed,
    input wire logic target_speed_valid,
    input wire logic limit_kill_error,
    input wire logic required_invalid_error
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_idle_speed_zero: assert property (!target_speed_valid |-> target_speed == 16'h0000)
        else $error("speed not zero while invalid");
    a_speed_clamp: assert property ($signed(target_speed) <= 3200
        && $signed(target_speed) >= -3200) else $error("speed beyond full scale");
    a_kill_stops: assert property (limit_kill_error |-> !target_speed_valid)
        else $error("speed valid during limit error");
    a_req_stops: assert property (required_invalid_error |-> !target_speed_valid)
        else $error("speed valid during required error");
    // outputs only move three edges after a strobe
    a_out_hold: assert property (!$past(adc_sample_valid, 3) |-> $stable(target_speed)
        && $stable(limit_kill_error)) else $error("outputs moved without a sample");
    a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write response late");
    a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
endmodule : asm_props
bind asm_analog_mixer asm_props asm_props_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .adc_sample_valid, .target_speed, .target_speed_valid, .limit_kill_error,
    .required_invalid_error);
`default_nettype wire

// ===== test/asm_pot_model.sv
// Purpose: pots or switches behind a two-channel converter
// Assumes: one conversion of both channels every fourth cycle
// Notes: lines toggle between strobes to expose stale captures
`timescale 1ns/10ps
`default_nettype none
module asm_pot_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] ch1_level,
    input wire logic [11:0] ch2_level,
    input wire logic [1:0] open_ch,
    output logic adc_sample_valid,
    output logic [11:0] throttle_channel_value,
    output logic [11:0] steering_channel_value,
    output logic [1:0] pot_disconnect
);
    logic [1:0] tick_reg; // conversion pacing
    initial begin
        tick_reg = 2'h0;
        {adc_sample_valid, throttle_channel_value, steering_channel_value, pot_disconnect} = 27'h0;
    end
    // free-running conversions, unsigned 12-bit codes
    always @(posedge aclk) begin
        tick_reg <= aresetn ? tick_reg + 2'h1 : 2'h0;
        adc_sample_valid <= aresetn && tick_reg == 2'h3;
        if (aresetn && tick_reg == 2'h3) begin
            throttle_channel_value <= ch1_level;
            steering_channel_value <= ch2_level;
            pot_disconnect <= open_ch;
        end else begin
            throttle_channel_value <= ~throttle_channel_value;
            steering_channel_value <= ~steering_channel_value;
            pot_disconnect <= ~pot_disconnect;
        end
    end
endmodule : asm_pot_model
`default_nettype wire

// ===== test/tb_top.sv
// Purpose: self-checking mixer bench
// Assumes: reset calibration values
// Notes: each case waits out four samples
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic aclk;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_val;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp, pot_disconnect, open_ch = 2'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic adc_sample_valid, target_speed_valid, limit_kill_error, required_invalid_error;
    logic [11:0] throttle_channel_value, steering_channel_value;
    logic [11:0] ch1_level = 12'h0, ch2_level = 12'h0;
    logic [15:0] target_speed;
    int fails = 0, cmp_count = 0;
    asm_analog_mixer dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .adc_sample_valid,
        .throttle_channel_value, .steering_channel_value, .pot_disconnect, .target_speed,
        .target_speed_valid, .limit_kill_error, .required_invalid_error, .irq);
    asm_pot_model pot_u (.aclk, .aresetn, .ch1_level, .ch2_level, .open_ch, .adc_sample_valid,
        .throttle_channel_value, .steering_channel_value, .pot_disconnect);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("FAIL at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        if (fails == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    // aw and w offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        rsp = s_axi_bresp;
        if (n == 64) begin
            fails++;
            end_of_test();
        end
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        rd_val = s_axi_rdata;
        rsp = s_axi_rresp;
        if (n == 64) begin
            fails++;
            end_of_test();
        end
    endtask : rd
    // control, levels, then speed check
    task automatic cs(input logic [31:0] c, input logic [11:0] a, input logic [11:0] b,
            input logic [1:0] o, input logic [18:0] e);
        wr(asm_pkg::OFF_CTRL, c);
        ch1_level <= a;
        ch2_level <= b;
        open_ch <= o;
        repeat (16) @(posedge aclk);
        chk({13'h0, target_speed, target_speed_valid, limit_kill_error, required_invalid_error},
            {13'h0, e});
    endtask : cs
    task automatic t_regs;
        rd(asm_pkg::OFF_CTRL);
        chk(rd_val, asm_pkg::CTRL_RST);
        rd(asm_pkg::OFF_CAL_BASE);
        chk(rd_val, asm_pkg::RANGE_RST);
        rd(8'h7c);
        chk({30'h0, rsp}, {30'h0, asm_pkg::RESP_SLVERR});
        wr(asm_pkg::OFF_CTRL, 32'hffff_ffff);
        chk({30'h0, rsp}, {30'h0, asm_pkg::RESP_OKAY});
        rd(asm_pkg::OFF_CTRL);
        chk(rd_val, asm_pkg::CTRL_MASK);
    endtask : t_regs
    // raw codes stay readable outside analog mode
    task automatic t_raw;
        cs(32'h0, 12'hfff, 12'h000, 2'h0, 19'h0);
        rd(asm_pkg::OFF_RAW);
        chk(rd_val, 32'h0000_0fff);
        cs(32'h2, 12'h123, 12'habc, 2'h0, 19'h0);
        rd(asm_pkg::OFF_RAW);
        chk(rd_val, 32'h0abc_0123);
    endtask : t_raw
    task automatic t_mix;
        cs(32'h1, 12'h900, 12'h880, 2'h0, {16'h0190, 3'b100});
        cs(32'h5, 12'h900, 12'h880, 2'h0, {16'h0258, 3'b100});
        cs(32'h9, 12'h900, 12'h880, 2'h0, {16'h00c8, 3'b100});
        cs(32'h1, 12'h000, 12'hfff, 2'h0, {16'hf382, 3'b100});
        cs(32'h5, 12'hfff, 12'hfff, 2'h0, {16'h0c80, 3'b100});
        cs(32'h9, 12'h000, 12'hfff, 2'h0, {16'hf380, 3'b100});
    endtask : t_mix
    // switch at and just above threshold
    task automatic t_switch;
        cs(32'h0c01, 12'h900, 12'hc00, 2'h0, {16'h0190, 3'b100});
        cs(32'h0c01, 12'h900, 12'hc01, 2'h0, {16'h0000, 3'b010});
        cs(32'h0c00, 12'h900, 12'hc01, 2'h0, {16'h0000, 3'b010});
        cs(32'h0401, 12'h900, 12'hc01, 2'h0, {16'h0000, 3'b010});
        cs(32'h0401, 12'h700, 12'hc01, 2'h0, {16'hfe72, 3'b100});
        cs(32'h0801, 12'h700, 12'hc01, 2'h0, {16'h0000, 3'b010});
    endtask : t_switch
    // open wiring, masking, ignore bit, clear
    task automatic t_disc;
        wr(asm_pkg::OFF_IRQ_MASK, 32'h4);
        cs(32'h0c01, 12'h900, 12'h400, 2'b10, {16'h0000, 3'b001});
        chk({31'h0, irq}, 32'h1);
        wr(asm_pkg::OFF_IRQ_MASK, 32'h0);
        repeat (4) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        cs(32'h0c11, 12'h900, 12'h400, 2'b10, {16'h0190, 3'b100});
        wr(asm_pkg::OFF_IRQ_MASK, 32'h4);
        repeat (4) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        wr(asm_pkg::OFF_STATUS, 32'h4);
        repeat (4) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
    endtask : t_disc
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_raw();
        t_mix();
        t_switch();
        t_disc();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
